// ---- bench/tb_spllc_top.sv ----
`timescale 1ns/100ps
module tb_spllc_top;
  import spllc_pkg::*;
  // ----------------------------------------
  // Signals and model state
  // ----------------------------------------
  logic sys_clk;
  logic rst;
  spllc_req_t req;
  logic [7:0] rdata;
  logic rvalid;
  spllc_pll_t pll_raw;
  spllc_ctl_t ctl;
  int num_errors;
  int check_count;
  logic [31:0] seed;
  logic [7:0] d;
  logic [7:0] mdl [int];
  logic [11:0] adr [8] = '{12'h280, 12'h281, 12'h282, 12'h284, 12'h285,
    12'h286, 12'h287, 12'h289};
  logic [7:0] en_seq [7] = '{8'h00, 8'h01, 8'h05, 8'h04, 8'h05, 8'h01, 8'h05};

  spllc_top dut_u (.sys_clk(sys_clk), .rst(rst), .req(req), .rdata(rdata),
    .rvalid(rvalid), .pll_raw(pll_raw), .ctl(ctl));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic stop_test;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic do_reset;
    rst <= 1'b1;
    mdl[SPLLC_ADDR_ENABLE] = SPLLC_RST_ENABLE;
    mdl[SPLLC_ADDR_LF_A] = SPLLC_RST_LF_A;
    mdl[SPLLC_ADDR_LF_B] = SPLLC_RST_LF_B;
    mdl[SPLLC_ADDR_LF_C] = SPLLC_RST_LF_C;
    mdl[SPLLC_ADDR_PUMP] = SPLLC_RST_PUMP;
    mdl[SPLLC_ADDR_PREDIV] = SPLLC_RST_PREDIV;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
  endtask

  // Model keeps only writable bits; status and unmapped are never stored
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    req.wr <= 1'b1;
    req.addr <= a;
    req.wdata <= v;
    @(posedge sys_clk);
    req.wr <= 1'b0;
    if (a == SPLLC_ADDR_ENABLE)
      mdl[a] = v & SPLLC_EN_WMASK;
    else if (a == SPLLC_ADDR_PREDIV)
      mdl[a] = v & SPLLC_PD_WMASK;
    else if (a >= SPLLC_ADDR_LF_A && a <= SPLLC_ADDR_PUMP)
      mdl[a] = v;
  endtask

  task automatic rd(input logic [11:0] a);
    logic [7:0] e;
    e = mdl.exists(a) ? mdl[a] : 8'h00;
    if (a == SPLLC_ADDR_STATE)
      e = {2'h0, pll_raw.band_high, pll_raw.band_low, pll_raw.cal_valid,
        2'h0, pll_raw.locked};
    @(posedge sys_clk);
    req.rd <= 1'b1;
    req.addr <= a;
    // Strobe lasts one cycle; the answer stands just after its edge
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      req.rd <= 1'b0;
      #1;
      if (rvalid === 1'b1)
        break;
    end
    if (rvalid !== 1'b1) begin
      num_errors++;
      $display("MISMATCH t=%0t no read answer", $time);
      stop_test();
    end else begin
      chk(rdata, e);
    end
  endtask

  // Write lands on the edge wr returns at; output flop shows it one edge on
  task automatic chk_ctl(input logic cal);
    spllc_ctl_t e;
    @(posedge sys_clk);
    #1;
    e.pll_on = mdl[SPLLC_ADDR_ENABLE][SPLLC_EN_ON_BIT];
    e.cal_start = cal;
    e.predivide_factor = (mdl[SPLLC_ADDR_PREDIV][1:0] == SPLLC_DIV_BY2) ?
      SPLLC_FACTOR_2 : SPLLC_FACTOR_4;
    e.lf_a = mdl[SPLLC_ADDR_LF_A];
    e.lf_b = mdl[SPLLC_ADDR_LF_B];
    e.lf_c = mdl[SPLLC_ADDR_LF_C];
    e.pump = mdl[SPLLC_ADDR_PUMP];
    e.cfg_bit = mdl[SPLLC_ADDR_PREDIV][SPLLC_PD_CFG_BIT];
    chk({2'h0, ctl}, {2'h0, e});
  endtask

  task automatic en_write(input logic [7:0] v);
    logic p;
    p = (v[0] & ~mdl[SPLLC_ADDR_ENABLE][0]) |
      (v[2] & ~mdl[SPLLC_ADDR_ENABLE][2]);
    wr(SPLLC_ADDR_ENABLE, v);
    chk_ctl(p);
    @(posedge sys_clk);
    #1;
    chk(ctl.cal_start, 1'b0);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    req = '0;
    pll_raw = '0;
    num_errors = 0;
    check_count = 0;
    seed = 32'h9e7b;
    do_reset();
    foreach (adr[k]) rd(adr[k]);
    for (int k = 0; k < 8; k++) begin
      seed = lfsr(seed);
      wr(adr[k], seed[7:0]);
      rd(adr[k]);
    end
    chk_ctl(1'b0);
    for (int c = 0; c < 4; c++) begin
      wr(SPLLC_ADDR_PREDIV, 8'h04 | c[7:0]);
      chk_ctl(1'b0);
    end
    wr(SPLLC_ADDR_LF_A, 8'h62);
    wr(SPLLC_ADDR_LF_B, 8'hc9);
    wr(SPLLC_ADDR_LF_C, 8'h0e);
    wr(SPLLC_ADDR_PUMP, 8'h12);
    wr(SPLLC_ADDR_PREDIV, 8'h05);
    chk_ctl(1'b0);
    foreach (en_seq[k]) en_write(en_seq[k]);
    repeat (8) begin
      seed = lfsr(seed);
      en_write(seed[7:0]);
    end
    for (int n = 0; n < 10; n++) begin
      seed = lfsr(seed);
      @(posedge sys_clk);
      pll_raw <= (n == 0) ? 4'hf : seed[3:0];
      repeat (6) @(posedge sys_clk);
      rd(SPLLC_ADDR_STATE);
    end
    // Reset in mid-run must bring every register back
    // Inputs quiet first, so status after reset is known without sync delay
    @(posedge sys_clk);
    pll_raw <= '0;
    do_reset();
    foreach (adr[k]) rd(adr[k]);
    chk_ctl(1'b0);
    stop_test();
  end
endmodule

// ---- inc/spllc_pkg.sv ----
package spllc_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [11:0] SPLLC_ADDR_ENABLE = 12'h280;
  localparam logic [11:0] SPLLC_ADDR_STATE = 12'h281;
  localparam logic [11:0] SPLLC_ADDR_LF_A = 12'h284;
  localparam logic [11:0] SPLLC_ADDR_LF_B = 12'h285;
  localparam logic [11:0] SPLLC_ADDR_LF_C = 12'h286;
  localparam logic [11:0] SPLLC_ADDR_PUMP = 12'h287;
  localparam logic [11:0] SPLLC_ADDR_PREDIV = 12'h289;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int SPLLC_EN_ON_BIT = 0;
  localparam int SPLLC_EN_RECAL_BIT = 2;
  localparam int SPLLC_ST_LOCK_BIT = 0;
  localparam int SPLLC_ST_CAL_BIT = 3;
  localparam int SPLLC_ST_LOW_BIT = 4;
  localparam int SPLLC_ST_HIGH_BIT = 5;
  localparam int SPLLC_PD_CFG_BIT = 2;
  localparam logic [7:0] SPLLC_EN_WMASK = 8'h05;
  localparam logic [7:0] SPLLC_PD_WMASK = 8'h07;

  // ----------------------------------------
  // Reset values and codes
  // ----------------------------------------
  localparam logic [7:0] SPLLC_RST_ENABLE = 8'h00;
  localparam logic [7:0] SPLLC_RST_LF_A = 8'h77;
  localparam logic [7:0] SPLLC_RST_LF_B = 8'h87;
  localparam logic [7:0] SPLLC_RST_LF_C = 8'h08;
  localparam logic [7:0] SPLLC_RST_PUMP = 8'h3f;
  localparam logic [7:0] SPLLC_RST_PREDIV = 8'h00;
  localparam logic [1:0] SPLLC_DIV_BY4 = 2'h0;
  localparam logic [1:0] SPLLC_DIV_BY2 = 2'h1;
  localparam logic [2:0] SPLLC_FACTOR_4 = 3'h4;
  localparam logic [2:0] SPLLC_FACTOR_2 = 3'h2;

  // Register access from the serial port
  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [7:0] wdata;
  } spllc_req_t;

  // Raw conditions from the analog PLL
  typedef struct packed {
    logic band_high;
    logic band_low;
    logic cal_valid;
    logic locked;
  } spllc_pll_t;

  // Controls towards the analog PLL
  typedef struct packed {
    logic pll_on;
    logic cal_start;
    logic [2:0] predivide_factor;
    logic [7:0] lf_a;
    logic [7:0] lf_b;
    logic [7:0] lf_c;
    logic [7:0] pump;
    logic cfg_bit;
  } spllc_ctl_t;

endpackage

// ---- rtl/spllc_sync.sv ----
`timescale 1ns/100ps
module spllc_sync (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Asynchronous level in, settled level out
  input wire logic async_in,
  output logic sync_out
);
  import spllc_pkg::*;

  logic [2:0] stage_q;
  logic [2:0] stage_d;
  logic out_q;
  logic out_d;

  always_comb begin
    stage_d = {stage_q[1:0], async_in};
    // Change counts only when second and third stages agree
    out_d = (stage_q[2] == stage_q[1]) ? stage_q[1] : out_q;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stage_q <= 3'h0;
      out_q <= 1'b0;
    end else begin
      stage_q <= stage_d;
      out_q <= out_d;
    end
  end

  assign sync_out = out_q;

endmodule

// ---- rtl/spllc_top.sv ----
`timescale 1ns/100ps
module spllc_top (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Register port
  input wire spllc_pkg::spllc_req_t req,
  output logic [7:0] rdata,
  output logic rvalid,
  // Analog PLL side
  input wire spllc_pkg::spllc_pll_t pll_raw,
  output spllc_pkg::spllc_ctl_t ctl
);
  import spllc_pkg::*;

  // ----------------------------------------
  // Status synchronisers
  // ----------------------------------------
  // One plain net per synchroniser, so each has a single driver
  logic sync_lock;
  logic sync_cal;
  logic sync_low;
  logic sync_high;
  spllc_pll_t pll_s;

  spllc_sync u_sync_lock (
    .sys_clk(sys_clk),
    .rst(rst),
    .async_in(pll_raw.locked),
    .sync_out(sync_lock)
  );
  spllc_sync u_sync_cal (
    .sys_clk(sys_clk),
    .rst(rst),
    .async_in(pll_raw.cal_valid),
    .sync_out(sync_cal)
  );
  spllc_sync u_sync_low (
    .sys_clk(sys_clk),
    .rst(rst),
    .async_in(pll_raw.band_low),
    .sync_out(sync_low)
  );
  spllc_sync u_sync_high (
    .sys_clk(sys_clk),
    .rst(rst),
    .async_in(pll_raw.band_high),
    .sync_out(sync_high)
  );

  assign pll_s = '{band_high: sync_high,
                   band_low: sync_low,
                   cal_valid: sync_cal,
                   locked: sync_lock};

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] enable_q, enable_d;
  logic [7:0] lf_a_q, lf_a_d;
  logic [7:0] lf_b_q, lf_b_d;
  logic [7:0] lf_c_q, lf_c_d;
  logic [7:0] pump_q, pump_d;
  logic [7:0] prediv_q, prediv_d;
  logic [7:0] state_flags;
  logic [7:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;
  logic cal_start_q, cal_start_d;
  spllc_ctl_t ctl_q, ctl_d;

  function automatic logic [2:0] predivide_of(input logic [1:0] code);
    // Codes 10 and 11 are undefined; they fall back to divide by four
    if (code == SPLLC_DIV_BY2) begin
      predivide_of = SPLLC_FACTOR_2;
    end else begin
      predivide_of = SPLLC_FACTOR_4;
    end
  endfunction

  always_comb begin
    state_flags = 8'h00;
    state_flags[SPLLC_ST_LOCK_BIT] = pll_s.locked;
    state_flags[SPLLC_ST_CAL_BIT] = pll_s.cal_valid;
    state_flags[SPLLC_ST_LOW_BIT] = pll_s.band_low;
    state_flags[SPLLC_ST_HIGH_BIT] = pll_s.band_high;
  end

  always_comb begin
    enable_d = enable_q;
    lf_a_d = lf_a_q;
    lf_b_d = lf_b_q;
    lf_c_d = lf_c_q;
    pump_d = pump_q;
    prediv_d = prediv_q;
    cal_start_d = 1'b0;
    if (req.wr) begin
      if (req.addr == SPLLC_ADDR_ENABLE) begin
        enable_d = req.wdata & SPLLC_EN_WMASK;
        // Calibration on a rising edge of either the enable or recal bit
        cal_start_d = (req.wdata[SPLLC_EN_RECAL_BIT] &
                       ~enable_q[SPLLC_EN_RECAL_BIT]) |
                      (req.wdata[SPLLC_EN_ON_BIT] &
                       ~enable_q[SPLLC_EN_ON_BIT]);
      end else if (req.addr == SPLLC_ADDR_LF_A) begin
        lf_a_d = req.wdata;
      end else if (req.addr == SPLLC_ADDR_LF_B) begin
        lf_b_d = req.wdata;
      end else if (req.addr == SPLLC_ADDR_LF_C) begin
        lf_c_d = req.wdata;
      end else if (req.addr == SPLLC_ADDR_PUMP) begin
        pump_d = req.wdata;
      end else if (req.addr == SPLLC_ADDR_PREDIV) begin
        prediv_d = req.wdata & SPLLC_PD_WMASK;
      end
    end
  end

  always_comb begin
    rvalid_d = req.rd;
    rdata_d = rdata_q;
    if (req.rd) begin
      if (req.addr == SPLLC_ADDR_ENABLE) begin
        rdata_d = enable_q;
      end else if (req.addr == SPLLC_ADDR_STATE) begin
        rdata_d = state_flags;
      end else if (req.addr == SPLLC_ADDR_LF_A) begin
        rdata_d = lf_a_q;
      end else if (req.addr == SPLLC_ADDR_LF_B) begin
        rdata_d = lf_b_q;
      end else if (req.addr == SPLLC_ADDR_LF_C) begin
        rdata_d = lf_c_q;
      end else if (req.addr == SPLLC_ADDR_PUMP) begin
        rdata_d = pump_q;
      end else if (req.addr == SPLLC_ADDR_PREDIV) begin
        rdata_d = prediv_q;
      end else begin
        rdata_d = 8'h00;
      end
    end
  end

  always_comb begin
    ctl_d.pll_on = enable_q[SPLLC_EN_ON_BIT];
    ctl_d.cal_start = cal_start_q;
    ctl_d.predivide_factor = predivide_of(prediv_q[1:0]);
    ctl_d.lf_a = lf_a_q;
    ctl_d.lf_b = lf_b_q;
    ctl_d.lf_c = lf_c_q;
    ctl_d.pump = pump_q;
    ctl_d.cfg_bit = prediv_q[SPLLC_PD_CFG_BIT];
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      enable_q <= SPLLC_RST_ENABLE;
      lf_a_q <= SPLLC_RST_LF_A;
      lf_b_q <= SPLLC_RST_LF_B;
      lf_c_q <= SPLLC_RST_LF_C;
      pump_q <= SPLLC_RST_PUMP;
      prediv_q <= SPLLC_RST_PREDIV;
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
      cal_start_q <= 1'b0;
      ctl_q <= '0;
    end else begin
      enable_q <= enable_d;
      lf_a_q <= lf_a_d;
      lf_b_q <= lf_b_d;
      lf_c_q <= lf_c_d;
      pump_q <= pump_d;
      prediv_q <= prediv_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
      cal_start_q <= cal_start_d;
      ctl_q <= ctl_d;
    end
  end

  assign rdata = rdata_q;
  assign rvalid = rvalid_q;
  assign ctl = ctl_q;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_recal_edge_pulse: assert property (@(posedge sys_clk)
    disable iff (rst)
    (req.wr && req.addr == SPLLC_ADDR_ENABLE &&
     req.wdata[SPLLC_EN_RECAL_BIT] && !enable_q[SPLLC_EN_RECAL_BIT])
    |=> ##1 ctl.cal_start)
    else $error("recal edge gave no calibration pulse");
  a_recal_level_quiet: assert property (@(posedge sys_clk)
    disable iff (rst)
    (req.wr && req.addr == SPLLC_ADDR_ENABLE &&
     enable_q[SPLLC_EN_RECAL_BIT] && enable_q[SPLLC_EN_ON_BIT] &&
     req.wdata[SPLLC_EN_ON_BIT])
    |=> ##1 !ctl.cal_start)
    else $error("calibration pulse without rising edge");
  a_enable_turns_on: assert property (@(posedge sys_clk)
    disable iff (rst)
    (req.wr && req.addr == SPLLC_ADDR_ENABLE &&
     req.wdata[SPLLC_EN_ON_BIT] && !enable_q[SPLLC_EN_ON_BIT])
    |=> ##1 (ctl.pll_on && ctl.cal_start))
    else $error("enable did not switch on and calibrate");
  a_high_flag_read: assert property (@(posedge sys_clk)
    disable iff (rst)
    (req.rd && req.addr == SPLLC_ADDR_STATE)
    |=> rdata[SPLLC_ST_HIGH_BIT] == $past(pll_s.band_high))
    else $error("high band flag misread");
  a_low_flag_read: assert property (@(posedge sys_clk)
    disable iff (rst)
    (req.rd && req.addr == SPLLC_ADDR_STATE)
    |=> rdata[SPLLC_ST_LOW_BIT] == $past(pll_s.band_low))
    else $error("low band flag misread");
  a_cal_flag_read: assert property (@(posedge sys_clk)
    disable iff (rst)
    (req.rd && req.addr == SPLLC_ADDR_STATE)
    |=> rdata[SPLLC_ST_CAL_BIT] == $past(pll_s.cal_valid))
    else $error("calibration flag misread");
  a_lock_flag_read: assert property (@(posedge sys_clk)
    disable iff (rst)
    (req.rd && req.addr == SPLLC_ADDR_STATE)
    |=> rdata[SPLLC_ST_LOCK_BIT] == $past(pll_s.locked))
    else $error("lock flag misread");
  a_lock_settles: assert property (@(posedge sys_clk)
    disable iff (rst)
    pll_raw.locked [*4] |=> pll_s.locked)
    else $error("lock not reported after steady input");
  // A settled change always carries the input seen three edges earlier
  a_sync_steady: assert property (@(posedge sys_clk)
    disable iff (rst)
    $changed(pll_s.cal_valid) |->
    pll_s.cal_valid == $past(pll_raw.cal_valid, 3))
    else $error("calibration flag moved without input");
  a_predivide_map: assert property (@(posedge sys_clk)
    disable iff (rst)
    (prediv_q[1:0] == SPLLC_DIV_BY2) |=>
    (ctl.predivide_factor == SPLLC_FACTOR_2))
    else $error("predivider factor wrong");
  a_predivide_four: assert property (@(posedge sys_clk)
    disable iff (rst)
    (prediv_q[1:0] != SPLLC_DIV_BY2) |=>
    (ctl.predivide_factor == SPLLC_FACTOR_4))
    else $error("divide by four factor wrong");

endmodule
